// File: logic/bcs_regs.svh
/*
  Timing figures and field constants of the block transfer sequencer.
  Assumes a single 200 MHz system clock; counts derive from the figures.
*/
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH
`define BCS_CLK_NS 5
`define BCS_STEP_NS 50
`define BCS_ACTIVE_NS 100
`define BCS_T42_T27_NS 25
`define BCS_T42_T28_NS 75
`define BCS_PASS_MIN_NS 2400
`define BCS_READ_DELAY_NS 300
`define BCS_WORD_NS 100
`define BCS_STEP_CYC ((`BCS_STEP_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_ACTIVE_CYC ((`BCS_ACTIVE_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_T27_CYC ((`BCS_T42_T27_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_T28_CYC ((`BCS_T42_T28_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_PASS_CYC ((`BCS_PASS_MIN_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_RDLY_CYC ((`BCS_READ_DELAY_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_WORD_CYC ((`BCS_WORD_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_EXT_W 24
`define BCS_MEM_W 18
`define BCS_REC_WORDS 8
`define BCS_SIGN_BIT 23
`endif

// File: logic/bcs_pkg.sv
/*
  Types of the block transfer sequencer: states, functions, stages and
  the operand groups. Assumes bcs_regs.svh is on the include path.
*/
`include "bcs_regs.svh"
package bcs_pkg;
  typedef enum logic [3:0] {
    BCS_ST_IDLE = 4'h1,
    BCS_ST_RUN = 4'h2,
    BCS_ST_ACCEPT = 4'h4,
    BCS_ST_RESUME = 4'h8
  } bcs_state_e;
  typedef enum logic [1:0] {
    BCS_FN_NORMAL, BCS_FN_FLAG, BCS_FN_CENTRAL, BCS_FN_MONITOR
  } bcs_func_e;
  // values run from zero upward, so each name equals its stage number
  typedef enum logic [5:0] {
    S_T00, S_T01, S_T02, S_T03, S_T04, S_T05, S_T06, S_T07, S_T08,
    S_T09, S_T10, S_T11, S_T12, S_T13, S_T14, S_T15, S_T16, S_T17,
    S_T18, S_T19, S_T20, S_T21, S_T22, S_T23, S_T24, S_T25, S_T26,
    S_T27, S_T28, S_T29, S_T30, S_T31, S_T32, S_T33, S_T34, S_T35,
    S_T36, S_T37, S_T38, S_T39, S_T40, S_T41, S_T42
  } bcs_stage_e;
  typedef struct packed {
    logic [`BCS_EXT_W-1:0] extended_address_source;
    logic [`BCS_MEM_W-1:0] memory_address_source;
    logic [`BCS_MEM_W-1:0] word_count_source;
  } bcs_source_s;
  typedef struct packed {
    logic [`BCS_MEM_W-1:0] mem_field_length_limit;
    logic [`BCS_EXT_W-1:0] ext_field_length_limit;
    logic [`BCS_MEM_W-1:0] mem_relocation_base;
    logic [`BCS_EXT_W-1:0] ext_relocation_base;
  } bcs_bounds_s;
endpackage

// File: logic/bcs_adder.sv
/*
  Adder with its result register. Every sum is written; the register
  self-clears one stage pair after the last write. Same clock as caller.
*/
`include "bcs_regs.svh"
module bcs_adder #(
  parameter int W = `BCS_EXT_W,
  parameter int CLR_CYC = `BCS_ACTIVE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] op_a,
  input wire logic [W-1:0] op_b,
  input wire logic cin,
  output logic [W-1:0] n_q
);
  logic [7:0] clr_q;

  if (CLR_CYC < 2 || CLR_CYC > 255) begin : g_chk
    $error("bcs_adder: CLR_CYC out of range");
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_q <= '0;
    end else if (load) begin
      n_q <= W'(op_a + op_b + {{(W-1){1'b0}}, cin});
    end else if (clr_q == 8'(CLR_CYC - 1)) begin
      n_q <= '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clr_q <= 8'h00;
    end else if (load || clr_q == 8'(CLR_CYC - 1)) begin
      clr_q <= 8'h00;
    end else begin
      clr_q <= clr_q + 8'h01;
    end
  end

  a_result_cleared: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clr_q == 8'(CLR_CYC - 1) && !load) |=> n_q == '0)
    else $error("result register not cleared");
endmodule

// File: logic/bcs_sequencer.sv
/*
  Timing-chain sequencer of the block transfer coupler: transfer setup,
  record setup, break-in and exchange sequences, word downcounter.
  Assumes the initiating party and the storage controller run on clk_sys.
*/
`include "bcs_regs.svh"
module bcs_sequencer #(
  parameter int REC_WORDS = `BCS_REC_WORDS,
  parameter int RDLY_CYC = `BCS_RDLY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic initiate,
  input wire logic read_req,
  input wire logic write_req,
  input wire bcs_pkg::bcs_func_e func,
  input wire bcs_pkg::bcs_source_s src,
  input wire bcs_pkg::bcs_bounds_s bounds,
  input wire logic [`BCS_MEM_W-1:0] monitor_addr,
  input wire logic accept,
  input wire logic break_in,
  input wire logic read_resume,
  input wire logic write_resume,
  output logic rw_flag,
  output bcs_pkg::bcs_stage_e chain_stage,
  output logic chain_busy,
  output logic ctl_req,
  output logic ctl_store,
  output logic [`BCS_EXT_W-1:0] ctl_addr,
  output logic mem_addr_load,
  output logic [`BCS_MEM_W-1:0] mem_addr,
  output logic downcount_go,
  output logic [2:0] word_downcounter,
  output logic end_of_op,
  output logic fl_error,
  output logic exchange_go,
  output logic monitor_flag,
  output logic flag_func_flag,
  output logic first_record_flag,
  output logic last_record_count_flag,
  output logic final_read_block_flag,
  output logic downcounter_enable_flag
);
  import bcs_pkg::*;

  localparam int STEP_CYC = `BCS_STEP_CYC;
  localparam int T27_CYC = `BCS_T27_CYC;
  localparam int T28_CYC = `BCS_T28_CYC;
  localparam int PASS_CYC = `BCS_PASS_CYC;
  localparam int WORD_CYC = `BCS_WORD_CYC;
  localparam int EW = `BCS_EXT_W;
  localparam int MW = `BCS_MEM_W;
  localparam int SB = `BCS_SIGN_BIT;

  if (REC_WORDS != 8 || RDLY_CYC < 1 || RDLY_CYC > 1023) begin : g_chk
    $error("bcs_sequencer: parameter out of range");
  end

  bcs_state_e state_q;
  bcs_stage_e stage_q;
  bcs_func_e func_q;
  logic [7:0] step_q;
  logic [9:0] pass_q;
  logic [9:0] dly_q;
  logic [7:0] word_q;
  logic read_q, brk_q, ecs_neg_q, mem_neg_q, pend_q;
  logic [EW-1:0] x_q, lt_q;
  logic [MW-1:0] a_q, b_q, k_q, a_hold_q;
  logic [EW-1:0] n_q, op_a, op_b;
  logic add_en, cin, ent, stall, normal, last_word;
  logic [7:0] lim;

  assign ent = state_q == BCS_ST_RUN && step_q == 8'h00;
  assign normal = func_q == BCS_FN_NORMAL;
  assign chain_stage = stage_q;
  assign chain_busy = state_q != BCS_ST_IDLE;
  assign ctl_addr = x_q;
  assign word_downcounter = word_q[2:0];
  // the next record's count may not load while the last one still drains
  assign stall = stage_q == S_T36 && downcounter_enable_flag;
  assign lim = stage_q == S_T42 ? 8'(T27_CYC) : 8'(STEP_CYC);
  // the cycle after the decrement that brings the count back to zero
  assign last_word = downcounter_enable_flag && downcount_go &&
    word_q[2:0] == 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // adder operand steering

  always_comb begin
    add_en = 1'b0;
    op_a = '0;
    op_b = '0;
    cin = 1'b0;
    if (ent && normal) begin
      unique case (stage_q)
        S_T08: begin
          add_en = 1'b1;
          op_a = EW'(b_q);
        end
        S_T12: begin
          add_en = 1'b1;
          op_a = EW'(a_q);
          op_b = EW'(k_q);
        end
        S_T16: begin
          add_en = 1'b1;
          op_a = EW'(bounds.mem_field_length_limit);
          // the T12 sum has self-cleared by now, so A+K is formed again
          op_b = ~(EW'(a_q) + EW'(k_q));
          cin = 1'b1;
        end
        S_T22: begin
          add_en = 1'b1;
          op_a = bounds.ext_field_length_limit;
          op_b = ~EW'(x_q + EW'(b_q));
          cin = 1'b1;
        end
        S_T24: begin
          add_en = 1'b1;
          op_a = x_q;
          op_b = bounds.ext_relocation_base;
        end
        S_T26: begin
          add_en = 1'b1;
          op_a = EW'(a_q);
          op_b = EW'(bounds.mem_relocation_base);
        end
        S_T28: begin
          add_en = 1'b1;
          op_a = {{(EW-3){1'b1}}, ~x_q[2:0]};
          op_b = brk_q ? '0 : EW'(REC_WORDS);
          cin = 1'b1;
        end
        S_T32: begin
          add_en = 1'b1;
          op_a = EW'(k_q);
          op_b = {{(EW-MW){1'b1}}, ~b_q};
          cin = 1'b1;
        end
        S_T34: begin
          add_en = 1'b1;
          op_a = x_q;
          op_b = EW'(k_q);
        end
        S_T42: begin
          add_en = 1'b1;
          op_a = EW'(a_q);
          op_b = EW'(k_q);
        end
        default: ;
      endcase
    end else if (ent && stage_q == S_T08) begin
      add_en = 1'b1;
      op_a = EW'(monitor_addr);
    end
  end

  bcs_adder #(.W(EW), .CLR_CYC(`BCS_ACTIVE_CYC)) i_bcs_adder (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(add_en),
    .op_a(op_a),
    .op_b(op_b),
    .cin(cin),
    .n_q(n_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // timing chain

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BCS_ST_IDLE;
      stage_q <= S_T00;
      step_q <= 8'h00;
    end else begin
      unique case (state_q)
        BCS_ST_IDLE: begin
          if (initiate && (read_req || write_req)) begin
            state_q <= BCS_ST_RUN;
            stage_q <= S_T00;
            step_q <= 8'h00;
          end
        end
        BCS_ST_RUN: begin
          if (ent && ((stage_q == S_T20 && normal && mem_neg_q) ||
              (stage_q == S_T25 && ecs_neg_q) ||
              (stage_q == S_T18 && func_q == BCS_FN_FLAG) ||
              (stage_q == S_T10 && !normal && func_q != BCS_FN_FLAG) ||
              (stage_q == S_T41 && last_record_count_flag))) begin
            state_q <= BCS_ST_IDLE;
          end else if (ent && stage_q == S_T40) begin
            state_q <= brk_q ? BCS_ST_RESUME : BCS_ST_ACCEPT;
          end else if (step_q == lim - 8'h01 && !stall) begin
            step_q <= 8'h00;
            stage_q <= stage_q == S_T42 ? S_T27 :
              bcs_stage_e'(stage_q + 6'h01);
          end else if (!stall) begin
            step_q <= step_q + 8'h01;
          end
        end
        BCS_ST_ACCEPT: begin
          if (accept && pass_q >= 10'(PASS_CYC)) begin
            state_q <= BCS_ST_RUN;
            stage_q <= S_T41;
            step_q <= 8'h00;
          end
        end
        BCS_ST_RESUME: begin
          if (read_resume || write_resume) begin
            state_q <= BCS_ST_RUN;
            stage_q <= S_T42;
            step_q <= 8'h00;
          end
        end
        default: state_q <= BCS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pass_q <= 10'h000;
    end else if (state_q == BCS_ST_IDLE) begin
      pass_q <= 10'h000;
    end else if (pass_q != 10'h3ff) begin
      pass_q <= pass_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer and record registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= BCS_FN_NORMAL;
      read_q <= 1'b0;
      rw_flag <= 1'b0;
    end else if (state_q == BCS_ST_IDLE && initiate &&
        (read_req || write_req)) begin
      func_q <= func;
      read_q <= read_req;
      rw_flag <= 1'b1;
    end else if (end_of_op) begin
      rw_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      x_q <= '0;
      a_q <= '0;
      b_q <= '0;
      k_q <= '0;
      a_hold_q <= '0;
      lt_q <= '0;
      ecs_neg_q <= 1'b0;
      mem_neg_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (ent) begin
      unique case (stage_q)
        S_T02: begin
          k_q <= '0;
          b_q <= '0;
        end
        S_T03: x_q <= src.extended_address_source;
        S_T05: begin
          a_q <= src.memory_address_source;
          b_q <= src.word_count_source;
        end
        S_T10: if (normal) k_q <= n_q[MW-1:0];
        // the sum self-clears before T20, so its sign is kept here
        S_T17: mem_neg_q <= n_q[SB] && normal;
        S_T21: k_q <= '0;
        S_T23: ecs_neg_q <= n_q[SB] && normal;
        S_T26: x_q <= n_q;
        S_T27: begin
          k_q <= '0;
          brk_q <= break_in;
        end
        S_T28: begin
          k_q <= brk_q ? '0 : MW'(REC_WORDS);
          a_hold_q <= n_q[MW-1:0];
        end
        S_T29: begin
          k_q <= '0;
          a_q <= a_hold_q;
        end
        S_T30: if (!brk_q) k_q <= n_q[MW-1:0];
        S_T33: lt_q <= n_q;
        S_T35: if (lt_q[SB]) b_q <= b_q - k_q;
        // the T34 sum has self-cleared by T38, so it is formed again
        S_T38: x_q <= x_q + EW'(k_q);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags and controller strobes

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      first_record_flag <= 1'b0;
      last_record_count_flag <= 1'b0;
      final_read_block_flag <= 1'b0;
      flag_func_flag <= 1'b0;
      monitor_flag <= 1'b0;
    end else if (ent) begin
      unique case (stage_q)
        S_T07: if (func_q == BCS_FN_FLAG) flag_func_flag <= 1'b0;
        S_T09: if (func_q == BCS_FN_FLAG) flag_func_flag <= 1'b1;
        S_T10: if (!normal && func_q != BCS_FN_FLAG) monitor_flag <= 1'b1;
        S_T11: last_record_count_flag <= 1'b0;
        S_T23: if (normal) first_record_flag <= 1'b1;
        S_T35: if (!lt_q[SB]) begin
          last_record_count_flag <= 1'b1;
          final_read_block_flag <= read_q;
        end
        S_T41: begin
          first_record_flag <= 1'b0;
          final_read_block_flag <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_req <= 1'b0;
      ctl_store <= 1'b0;
      mem_addr_load <= 1'b0;
      mem_addr <= '0;
      exchange_go <= 1'b0;
    end else begin
      ctl_req <= ent && ((stage_q == S_T29 && !brk_q) ||
        (stage_q == S_T12 && func_q == BCS_FN_FLAG));
      ctl_store <= !read_q;
      exchange_go <= ent && stage_q == S_T10 &&
        func_q == BCS_FN_CENTRAL;
      mem_addr_load <= ent && ((stage_q == S_T29 && first_record_flag) ||
        (stage_q == S_T10 && !normal && func_q != BCS_FN_FLAG));
      if (ent && stage_q == S_T29) mem_addr <= a_hold_q;
      else if (ent && stage_q == S_T10) mem_addr <= n_q[MW-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      end_of_op <= 1'b0;
      fl_error <= 1'b0;
    end else begin
      fl_error <= ent && ((stage_q == S_T20 && normal && mem_neg_q) ||
        (stage_q == S_T25 && ecs_neg_q));
      end_of_op <= (ent && ((stage_q == S_T20 && normal && mem_neg_q) ||
        (stage_q == S_T25 && ecs_neg_q) ||
        (stage_q == S_T18 && func_q == BCS_FN_FLAG) ||
        (stage_q == S_T10 && !normal && func_q != BCS_FN_FLAG))) ||
        (last_record_count_flag && !chain_busy && last_word);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // word downcounter and read delay chain

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      downcounter_enable_flag <= 1'b0;
      pend_q <= 1'b0;
      dly_q <= 10'h000;
    end else begin
      if (ent && stage_q == S_T39) begin
        downcounter_enable_flag <= 1'b0;
        dly_q <= read_q ? 10'(RDLY_CYC) : 10'h000;
      end else begin
        if (dly_q != 10'h000) dly_q <= dly_q - 10'h001;
        if (pend_q && dly_q == 10'h000) begin
          downcounter_enable_flag <= 1'b1;
        end else if (last_word) begin
          downcounter_enable_flag <= 1'b0;
        end
      end
      if (ent && stage_q == S_T41) pend_q <= 1'b1;
      else if (dly_q == 10'h000) pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= 8'h00;
      downcount_go <= 1'b0;
    end else begin
      downcount_go <= 1'b0;
      if (ent && stage_q == S_T37 && last_record_count_flag) begin
        word_q <= {5'h00, b_q[2:0]};
      end else if (ent && stage_q == S_T38 && !last_record_count_flag) begin
        word_q <= {5'h00, k_q[2:0]};
      end else if (downcounter_enable_flag && !last_word) begin
        // one word per 100 ns: counter paces in the upper bits; a loaded
        // zero wraps through seven, so a full record runs eight words
        if (word_q[7:3] == 5'(WORD_CYC - 1)) begin
          word_q <= {5'h00, word_q[2:0] - 3'h1};
          downcount_go <= 1'b1;
        end else begin
          word_q <= {word_q[7:3] + 5'h01, word_q[2:0]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_start_chain: assert property (
    state_q == BCS_ST_IDLE && initiate && read_req |=>
    rw_flag && stage_q == S_T00 && state_q == BCS_ST_RUN)
    else $error("chain did not start at T00");
  a_stage_spacing: assert property (
    ent && stage_q == S_T05 |-> ##10 ent && stage_q == S_T06)
    else $error("stages not 50 ns apart");
  a_restart_offset: assert property (
    ent && stage_q == S_T42 |-> ##5 (ent && stage_q == S_T27)
    ##10 (ent && stage_q == S_T28))
    else $error("T27 or T28 offset wrong after T42");
  a_mem_bound_err: assert property (
    ent && stage_q == S_T20 && normal && mem_neg_q |=>
    fl_error && end_of_op && state_q == BCS_ST_IDLE)
    else $error("memory bound error not signalled");
  a_first_flag: assert property (
    ent && stage_q == S_T23 && normal |=> first_record_flag)
    else $error("first-record flag not set");
  a_count_forced: assert property (
    ent && stage_q == S_T28 && !brk_q |=> k_q == MW'(REC_WORDS))
    else $error("record count not forced");
  a_break_hold: assert property (
    ent && stage_q == S_T28 && brk_q |=> k_q == '0 ##10 k_q == '0)
    else $error("count not held clear on break-in");
  a_break_block: assert property (
    ent && stage_q == S_T29 && brk_q |=> !ctl_req)
    else $error("address sent during break-in");
  a_last_load: assert property (
    ent && stage_q == S_T37 && last_record_count_flag |=>
    word_q[2:0] == $past(b_q[2:0]))
    else $error("last record count not loaded");
  a_last_end: assert property (
    last_word && last_record_count_flag && !chain_busy |=> end_of_op)
    else $error("no end of operation on last word");

  c_flag_func: cover property (ent && stage_q == S_T18 &&
    func_q == BCS_FN_FLAG);
  c_break_resume: cover property (state_q == BCS_ST_RESUME &&
    read_resume);
  c_record_accept: cover property (state_q == BCS_ST_ACCEPT && accept);
  c_transfer_end: cover property (end_of_op && !fl_error && normal);
endmodule

// File: bench/bcs_ctl_model.sv
/*
  Storage controller stand-in: answers each record request with accept.
  Assumes it shares clk_sys with the sequencer.
*/
module bcs_ctl_model #(
  parameter int DLY = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ctl_req,
  input wire logic chain_busy,
  input wire bcs_pkg::bcs_stage_e chain_stage,
  output logic accept
);
  timeunit 1ns;
  timeprecision 100ps;
  import bcs_pkg::*;
  int cnt;
  ////////////////////////////////////////////////////////////////////////////
  // accept holds until T41 takes it or the chain goes idle; a stale one would start a later record
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      accept <= 1'b0;
    end else begin
      if (ctl_req) cnt <= DLY;
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) accept <= 1'b1;
      else if (chain_stage == S_T41 || !chain_busy) accept <= 1'b0;
    end
  end
endmodule

// File: bench/test_block_transfer_coupler_sequencer.sv
/*
  Self-checking bench of the block transfer sequencer.
  Assumes bcs_pkg is compiled first and the controller model is present.
*/
module test_block_transfer_coupler_sequencer import bcs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, rst_n = 0, initiate = 0, read_req = 0, write_req = 0;
  logic accept, break_in = 0, read_resume = 0, write_resume = 0;
  bcs_func_e func = BCS_FN_NORMAL;
  bcs_source_s src = '0;
  bcs_bounds_s bounds = '{18'h01000, 24'h010000, 18'h00040, 24'h000100};
  logic [17:0] monitor_addr = 18'h00321, mem_addr, got_a;
  logic rw_flag, chain_busy, ctl_req, ctl_store, mem_addr_load;
  logic downcount_go, end_of_op, fl_error, exchange_go, monitor_flag;
  logic flag_func_flag, first_record_flag, last_record_count_flag;
  logic final_read_block_flag, downcounter_enable_flag, got_s, got_f;
  bcs_stage_e chain_stage;
  logic [23:0] ctl_addr, n_go, n_req, n_err, n_xg, got_x;
  logic [2:0] word_downcounter;
  int num_errors = 0, total_checks = 0, w;
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 clk_sys = ~clk_sys;
  bcs_sequencer i_bcs_sequencer (.clk_sys, .rst_n, .initiate, .read_req,
    .write_req, .func, .src, .bounds, .monitor_addr, .accept, .break_in,
    .read_resume, .write_resume, .rw_flag, .chain_stage, .chain_busy,
    .ctl_req, .ctl_store, .ctl_addr, .mem_addr_load, .mem_addr,
    .downcount_go, .word_downcounter, .end_of_op, .fl_error, .exchange_go,
    .monitor_flag, .flag_func_flag, .first_record_flag,
    .last_record_count_flag, .final_read_block_flag,
    .downcounter_enable_flag);
  bcs_ctl_model i_bcs_ctl_model (.clk_sys, .rst_n, .ctl_req, .chain_busy,
    .chain_stage, .accept);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one transfer start to end; pulses are tallied once per cycle
  task automatic run(input bcs_func_e f, input logic [23:0] x,
    input logic [17:0] a, input logic [17:0] b, input logic rd,
    input logic brk);
    int i;
    n_go = 0;
    n_req = 0;
    n_err = 0;
    n_xg = 0;
    w = 0;
    got_a = '0;
    got_x = '0;
    got_s = 1'b0;
    got_f = 1'b0;
    func = f;
    src = '{x, a, b};
    read_req = rd;
    write_req = !rd;
    break_in = brk;
    initiate = 1;
    @(posedge clk_sys);
    #1 initiate = 0;
    chk(rw_flag, 1);
    for (i = 0; i < 9000 && end_of_op !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1 n_go += downcount_go;
      n_req += ctl_req;
      n_err += fl_error;
      n_xg += exchange_go;
      if (mem_addr_load) got_a = mem_addr;
      if (ctl_req) got_x = ctl_addr;
      if (ctl_req) got_s = ctl_store;
      if (chain_stage == S_T40) got_f = final_read_block_flag;
      if (chain_stage == S_T28) break_in = 0;
      // resume stands for exactly the one edge at which the wait takes it
      if (w >= 30 || (brk && !break_in && chain_stage == S_T40)) w++;
      write_resume = w == 30;
    end
    if (end_of_op !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t transfer timed out", $time);
      complete_run;
    end else begin
      @(posedge clk_sys);
      #1 chk(rw_flag, 0);
      repeat (3) @(posedge clk_sys);
      #1 chk(chain_busy, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1 repeat (8) @(posedge clk_sys);
    #1 rst_n = 1;
    chk(chain_busy, 0);
    chk(downcounter_enable_flag | first_record_flag, 0);
    run(BCS_FN_NORMAL, 24'h10, 18'h100, 18'd3, 0, 0);
    chk(n_req, 1);
    chk(n_go, 3);
    chk(got_a, 18'h140);
    chk(got_x, 24'h110);
    chk(got_s, 1);
    chk(got_f, 0);
    chk(last_record_count_flag, 1);
    $display("test 1 done");
    run(BCS_FN_NORMAL, 24'h15, 18'h200, 18'd13, 1, 0);
    chk(n_req, 3);
    chk(n_go, 13);
    chk(got_a, 18'h240);
    chk(got_x, 24'h120);
    chk(got_s, 0);
    chk(got_f, 1);
    $display("test 2 done");
    run(BCS_FN_NORMAL, 24'h20, 18'h100, 18'd8, 0, 0);
    chk(n_req, 1);
    chk(n_go, 8);
    $display("test 3 done");
    run(BCS_FN_NORMAL, 24'h10, 18'h0ff8, 18'd16, 0, 0);
    chk(n_err, 1);
    chk(n_req | n_go, 0);
    chk(last_record_count_flag, 0);
    $display("test 4 done");
    run(BCS_FN_NORMAL, 24'hfffc, 18'h100, 18'd8, 0, 0);
    chk(n_err, 1);
    chk(n_req | n_go, 0);
    $display("test 5 done");
    run(BCS_FN_CENTRAL, 24'h0, 18'h0, 18'd0, 0, 0);
    chk(n_xg, 1);
    chk(got_a, monitor_addr);
    chk(monitor_flag, 1);
    $display("test 6 done");
    run(BCS_FN_MONITOR, 24'h0, 18'h0, 18'd0, 0, 0);
    chk(n_xg, 0);
    $display("test 7 done");
    run(BCS_FN_FLAG, 24'h800005, 18'h0, 18'd0, 0, 0);
    chk(n_req, 1);
    chk(got_x, 24'h800005);
    chk(flag_func_flag, 1);
    $display("test 8 done");
    run(BCS_FN_NORMAL, 24'h10, 18'h100, 18'd11, 0, 1);
    chk(n_req, 2);
    chk(n_go, 11);
    chk(got_a, 18'h140);
    chk(got_x, 24'h118);
    $display("test 9 done");
    complete_run;
  end
endmodule
